// ---- cbreg_host.sv ----
`timescale 1ns/1ps
// ****
// Host side byte access model
// ****
module cbreg_host
  import cbreg_pkg::*;
(
  input  wire logic       ref_clk,
  output cbreg_req_t      req,
  input  wire cbreg_rsp_t rsp
);
  initial req = '0;
  // Released lines carry the inverse so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 d = rsp.rdata;
    v = rsp.valid;
  endtask : rd
endmodule : cbreg_host

// ---- cbreg_pkg.sv ----
package cbreg_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] CBREG_OFF_REV_VENDOR = 8'h05;
  localparam logic [7:0] CBREG_OFF_DEVICE     = 8'h06;
  localparam logic [7:0] CBREG_OFF_BYTE_COUNT = 8'h07;
  localparam logic [7:0] CBREG_OFF_MASK_LOW   = 8'h08;
  localparam logic [7:0] CBREG_OFF_MASK_MID   = 8'h09;
  localparam logic [7:0] CBREG_OFF_MASK_HIGH  = 8'h0A;
  localparam logic [7:0] CBREG_OFF_IMP_19_17  = 8'h0B;
  localparam logic [7:0] CBREG_OFF_IMP_16_15  = 8'h0C;

  // ********************************************************
  // Identity codes (values arbitrary) and reset values
  // ********************************************************
  localparam logic [3:0] CBREG_REVISION_CODE  = 4'h2;
  localparam logic [3:0] CBREG_VENDOR_CODE    = 4'h9;
  localparam logic [7:0] CBREG_DEVICE_CODE    = 8'hA5;
  localparam logic [4:0] CBREG_BYTE_COUNT_RST = 5'h08;
  localparam logic [7:0] CBREG_MASK_RST       = 8'h00;
  localparam logic [7:0] CBREG_IMP_RST        = 8'h00;

  // ********************************************************
  // Field layout
  // ********************************************************
  localparam int CBREG_NUM_OUT     = 20;
  localparam int CBREG_IMP_FIRST   = 15;
  localparam int CBREG_NUM_IMP     = 5;
  localparam int CBREG_BC_WIDTH    = 5;
  localparam logic [7:0] CBREG_MASK_HIGH_WMASK = 8'h0F;
  localparam logic [7:0] CBREG_IMP_A_WMASK     = 8'hDB;
  localparam logic [7:0] CBREG_IMP_B_WMASK     = 8'h6C;

  localparam logic [1:0] CBREG_Z_NOMINAL = 2'h0;
  localparam logic [1:0] CBREG_Z_MINUS5  = 2'h1;
  localparam logic [1:0] CBREG_Z_PLUS5   = 2'h2;
  localparam logic [1:0] CBREG_Z_NOM_ALT = 2'h3;

  // Byte access request from the serial engine
  typedef struct packed {
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbreg_req_t;

  // Read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } cbreg_rsp_t;

endpackage : cbreg_pkg

// ---- cbreg_regs.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Read-only byte: revision high, vendor low nibble
// - Read-only fixed device code byte, writes ignored
// - Byte count resets to eight; bits 7:5 zero
// - Masks act only while sideband enable high
// - Mask one forces enable; zero lets shift disable
// - Mask bytes map outputs 7..0, 15..8, 19..16
// - Masks read/write, reset zero, upper nibble zero
// - Impedance code: 00/11 nominal, 01 minus, 10 plus
// - First impedance byte: outputs 19, 18, 17
// - Second impedance byte: outputs 16, 15
// - Impedance bits read/write, reset to nominal
// - Access only via block transfers at slave address
// - Bytes completed before stop are kept
module cbreg_regs
  import cbreg_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  input  wire cbreg_req_t              req,
  input  wire logic                    sideband_enable_input,
  input  wire logic [CBREG_NUM_OUT-1:0] sideband_shift_enable,
  output cbreg_rsp_t                   rsp,
  output logic      [CBREG_BC_WIDTH-1:0] read_byte_count,
  output logic      [CBREG_NUM_OUT-1:0] clock_output_enable,
  output logic      [2*CBREG_NUM_IMP-1:0] impedance_sel
);

  // ********************************************************
  // Storage
  // ********************************************************
  logic [CBREG_BC_WIDTH-1:0]  byte_count_r;
  logic [CBREG_NUM_OUT-1:0]   mask_r;
  logic [7:0]                 imp_a_r;
  logic [7:0]                 imp_b_r;
  logic                       clk_en_wr;

  assign clk_en_wr = clk_en & req.wr_stb;

  // Each byte commits on its own strobe, so a stop after any byte keeps it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      byte_count_r <= CBREG_BYTE_COUNT_RST;
      mask_r       <= {CBREG_MASK_RST[3:0], CBREG_MASK_RST, CBREG_MASK_RST};
      imp_a_r      <= CBREG_IMP_RST;
      imp_b_r      <= CBREG_IMP_RST;
    end else if (clk_en_wr) begin
      case (req.addr)
        CBREG_OFF_BYTE_COUNT: byte_count_r <= req.wdata[CBREG_BC_WIDTH-1:0];
        CBREG_OFF_MASK_LOW:   mask_r[7:0]  <= req.wdata;
        CBREG_OFF_MASK_MID:   mask_r[15:8] <= req.wdata;
        CBREG_OFF_MASK_HIGH:  mask_r[19:16] <= req.wdata[3:0];
        CBREG_OFF_IMP_19_17:  imp_a_r <= req.wdata & CBREG_IMP_A_WMASK;
        CBREG_OFF_IMP_16_15:  imp_b_r <= req.wdata & CBREG_IMP_B_WMASK;
        default: ;
      endcase
    end
  end

  // ********************************************************
  // Read decode
  // ********************************************************
  logic [7:0] rd_mux;
  assign rd_mux =
    (req.addr == CBREG_OFF_REV_VENDOR) ? {CBREG_REVISION_CODE, CBREG_VENDOR_CODE} :
    (req.addr == CBREG_OFF_DEVICE)     ? CBREG_DEVICE_CODE :
    (req.addr == CBREG_OFF_BYTE_COUNT) ? {3'h0, byte_count_r} :
    (req.addr == CBREG_OFF_MASK_LOW)   ? mask_r[7:0] :
    (req.addr == CBREG_OFF_MASK_MID)   ? mask_r[15:8] :
    (req.addr == CBREG_OFF_MASK_HIGH)  ? {4'h0, mask_r[19:16]} :
    (req.addr == CBREG_OFF_IMP_19_17)  ? imp_a_r :
    (req.addr == CBREG_OFF_IMP_16_15)  ? imp_b_r : 8'h00;

  // ********************************************************
  // Output enable gating and impedance selectors
  // ********************************************************
  logic [CBREG_NUM_OUT-1:0]   oe_nxt;
  logic [2*CBREG_NUM_IMP-1:0] imp_nxt;

  genvar g;
  generate
    for (g = 0; g < CBREG_NUM_OUT; g++) begin : g_oe
      // Masks matter only in sideband mode; otherwise outputs stay enabled here
      assign oe_nxt[g] = ~sideband_enable_input | mask_r[g] | sideband_shift_enable[g];
    end
  endgenerate

  // Pair order: higher bit is the leading digit of the code
  assign imp_nxt[9:8] = imp_a_r[7:6];
  assign imp_nxt[7:6] = imp_a_r[4:3];
  assign imp_nxt[5:4] = imp_a_r[1:0];
  assign imp_nxt[3:2] = imp_b_r[6:5];
  assign imp_nxt[1:0] = imp_b_r[3:2];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp                 <= '0;
      read_byte_count     <= CBREG_BYTE_COUNT_RST;
      clock_output_enable <= '1;
      impedance_sel       <= '0;
    end else if (clk_en) begin
      rsp.valid           <= req.rd_stb;
      rsp.rdata           <= req.rd_stb ? rd_mux : 8'h00;
      read_byte_count     <= byte_count_r;
      clock_output_enable <= oe_nxt;
      impedance_sel       <= imp_nxt;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_wr_bc;
    clk_en && req.wr_stb && req.addr == CBREG_OFF_BYTE_COUNT;
  endsequence

  a_bc_write_lands: assert property (s_wr_bc |=> ##1 (read_byte_count == $past(req.wdata[4:0], 2)) || !$past(clk_en))
    else $error("Byte count write not applied");
  a_id_rev_vendor: assert property (clk_en && req.rd_stb && req.addr == CBREG_OFF_REV_VENDOR |=>
      rsp.rdata == {CBREG_REVISION_CODE, CBREG_VENDOR_CODE})
    else $error("Revision/vendor byte wrong");
  a_id_device_fixed: assert property (clk_en && req.rd_stb && req.addr == CBREG_OFF_DEVICE |=>
      rsp.rdata == CBREG_DEVICE_CODE)
    else $error("Device byte wrong");
  a_bc_upper_zero: assert property (clk_en && req.rd_stb && req.addr == CBREG_OFF_BYTE_COUNT |=> rsp.rdata[7:5] == 3'h0)
    else $error("Byte count reserved bits set");
  a_mask_disabled: assert property (clk_en && !sideband_enable_input |=> clock_output_enable == '1)
    else $error("Mask active with sideband off");
  a_mask_forces_on: assert property (clk_en && sideband_enable_input |=>
      clock_output_enable == ($past(mask_r) | $past(sideband_shift_enable)))
    else $error("Sideband gating wrong");
  a_mask_high_rsvd: assert property (clk_en && req.rd_stb && req.addr == CBREG_OFF_MASK_HIGH |=> rsp.rdata[7:4] == 4'h0)
    else $error("Mask reserved bits set");
  a_imp_rsvd_zero: assert property (clk_en && req.rd_stb && req.addr == CBREG_OFF_IMP_16_15 |=> (rsp.rdata & 8'h93) == 8'h00)
    else $error("Impedance reserved bits set");
  a_imp_map_out19: assert property (clk_en |=> impedance_sel[9:8] == $past(imp_a_r[7:6]))
    else $error("Output 19 impedance mapping wrong");

  // ********************************************************
  // Read path checks
  // ********************************************************
  sequence s_rd_at(logic [7:0] a);
    clk_en && req.rd_stb && req.addr == a;
  endsequence

  sequence s_wr_at(logic [7:0] a);
    clk_en && req.wr_stb && req.addr == a;
  endsequence

  // Idle answers read zero, so a late sample never sees stale data as valid
  a_rsp_valid_pulse: assert property (clk_en |=> rsp.valid == $past(req.rd_stb))
    else $error("Read answer valid does not follow strobe");
  a_rsp_idle_zero: assert property (clk_en && !req.rd_stb |=> rsp.rdata == 8'h00)
    else $error("Read data not zero while idle");
  a_unmapped_zero: assert property (clk_en && req.rd_stb &&
      (req.addr < CBREG_OFF_REV_VENDOR || req.addr > CBREG_OFF_IMP_16_15) |=> rsp.rdata == 8'h00)
    else $error("Unmapped read not zero");
  a_bc_read_back: assert property (s_rd_at(CBREG_OFF_BYTE_COUNT) |=> rsp.rdata[4:0] == $past(byte_count_r))
    else $error("Byte count read back wrong");
  // A read in the same cycle as a write returns the old byte
  a_mask_low_read: assert property (s_rd_at(CBREG_OFF_MASK_LOW) |=> rsp.rdata == $past(mask_r[7:0]))
    else $error("Low mask read back wrong");
  a_mask_mid_read: assert property (s_rd_at(CBREG_OFF_MASK_MID) |=> rsp.rdata == $past(mask_r[15:8]))
    else $error("Middle mask read back wrong");
  a_imp_a_rsvd: assert property (s_rd_at(CBREG_OFF_IMP_19_17) |=> (rsp.rdata & 8'h24) == 8'h00)
    else $error("First impedance byte reserved bits set");
  a_imp_a_read: assert property (s_rd_at(CBREG_OFF_IMP_19_17) |=> rsp.rdata == $past(imp_a_r))
    else $error("First impedance byte read back wrong");
  a_imp_b_read: assert property (s_rd_at(CBREG_OFF_IMP_16_15) |=> rsp.rdata == $past(imp_b_r))
    else $error("Second impedance byte read back wrong");

  // ********************************************************
  // Write path checks
  // ********************************************************
  a_bc_store: assert property (s_wr_at(CBREG_OFF_BYTE_COUNT) |=> byte_count_r == $past(req.wdata[4:0]))
    else $error("Byte count not stored");
  a_mask_low_store: assert property (s_wr_at(CBREG_OFF_MASK_LOW) |=> mask_r[7:0] == $past(req.wdata))
    else $error("Low mask not stored");
  a_mask_mid_store: assert property (s_wr_at(CBREG_OFF_MASK_MID) |=> mask_r[15:8] == $past(req.wdata))
    else $error("Middle mask not stored");
  a_mask_high_store: assert property (s_wr_at(CBREG_OFF_MASK_HIGH) |=> mask_r[19:16] == $past(req.wdata[3:0]))
    else $error("High mask not stored");
  a_imp_a_store: assert property (s_wr_at(CBREG_OFF_IMP_19_17) |=>
      imp_a_r == ($past(req.wdata) & CBREG_IMP_A_WMASK))
    else $error("First impedance byte not stored");
  a_imp_b_store: assert property (s_wr_at(CBREG_OFF_IMP_16_15) |=>
      imp_b_r == ($past(req.wdata) & CBREG_IMP_B_WMASK))
    else $error("Second impedance byte not stored");

  // ********************************************************
  // Output stage and register hold checks
  // ********************************************************
  a_bc_follows_reg: assert property (clk_en |=> read_byte_count == $past(byte_count_r))
    else $error("Byte count output lags register");
  a_imp_map_out18: assert property (clk_en |=> impedance_sel[7:6] == $past(imp_a_r[4:3]))
    else $error("Output 18 impedance mapping wrong");
  a_imp_map_out17: assert property (clk_en |=> impedance_sel[5:4] == $past(imp_a_r[1:0]))
    else $error("Output 17 impedance mapping wrong");
  a_imp_map_out16: assert property (clk_en |=> impedance_sel[3:2] == $past(imp_b_r[6:5]))
    else $error("Output 16 impedance mapping wrong");
  a_imp_map_out15: assert property (clk_en |=> impedance_sel[1:0] == $past(imp_b_r[3:2]))
    else $error("Output 15 impedance mapping wrong");
  // A low enable holds every flop, so a stalled engine sees a steady bank
  a_freeze_outputs: assert property (!clk_en |=> $stable(rsp) && $stable(read_byte_count) &&
      $stable(clock_output_enable) && $stable(impedance_sel))
    else $error("Outputs moved while clock enable low");
  a_freeze_store: assert property (!clk_en |=> $stable(mask_r) && $stable(byte_count_r) &&
      $stable(imp_a_r) && $stable(imp_b_r))
    else $error("Registers moved while clock enable low");

endmodule : cbreg_regs

// ---- testbench.sv ----
`timescale 1ns/1ps
// ****
// Register bank bench
// ****
module testbench;
  import cbreg_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic        sideband_enable_input = 1'b0;
  logic [19:0] sideband_shift_enable = 20'h00000;
  logic [4:0]  read_byte_count;
  logic [19:0] clock_output_enable;
  logic [9:0]  impedance_sel;
  cbreg_req_t  req;
  cbreg_rsp_t  rsp;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  rst_tab [8] = '{8'h29, 8'hA5, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  ff_tab [8] = '{8'h29, 8'hA5, 8'h1F, 8'hFF, 8'hFF, 8'h0F, 8'hDB, 8'h6C};
  always #12.5 ref_clk = ~ref_clk;
  cbreg_host host (.ref_clk(ref_clk), .req(req), .rsp(rsp));
  cbreg_regs uut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .req(req),
    .sideband_enable_input(sideband_enable_input), .sideband_shift_enable(sideband_shift_enable),
    .rsp(rsp), .read_byte_count(read_byte_count), .clock_output_enable(clock_output_enable),
    .impedance_sel(impedance_sel));
  task automatic results;
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk({11'h000, v, d}, {11'h001, e});
  endtask : rchk
  // Registered outputs trail a write by two edges and an input change by one edge
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(8'h05 + 8'(i), rst_tab[i]);
    chk({15'h0000, read_byte_count}, 20'h00008);
    chk({10'h000, impedance_sel}, 20'h00000);
    for (int i = 0; i < 8; i++) host.wr(8'h05 + 8'(i), 8'hFF);
    for (int i = 0; i < 8; i++) rchk(8'h05 + 8'(i), ff_tab[i]);
    chk({15'h0000, read_byte_count}, 20'h0001F);
    host.wr(8'h20, 8'hFF);
    rchk(8'h20, 8'h00);
    host.wr(8'h07, 8'h03);
    settle();
    chk({15'h0000, read_byte_count}, 20'h00003);
    host.wr(8'h0B, 8'h4A);
    host.wr(8'h0C, 8'h24);
    rchk(8'h0B, 8'h4A);
    rchk(8'h0C, 8'h24);
    settle();
    chk({10'h000, impedance_sel}, 20'h00165);
    host.wr(8'h08, 8'h81);
    host.wr(8'h09, 8'h02);
    host.wr(8'h0A, 8'h18);
    rchk(8'h0A, 8'h08);
    @(posedge ref_clk) sideband_shift_enable <= 20'h00010;
    settle();
    chk(clock_output_enable, 20'hFFFFF);
    @(posedge ref_clk) sideband_enable_input <= 1'b1;
    settle();
    chk(clock_output_enable, 20'h80291);
    // Enable low: writes and input changes must not reach the bank
    @(posedge ref_clk) clk_en <= 1'b0;
    host.wr(8'h08, 8'h55);
    @(posedge ref_clk) sideband_shift_enable <= 20'h00000;
    settle();
    chk(clock_output_enable, 20'h80291);
    @(posedge ref_clk) clk_en <= 1'b1;
    rchk(8'h08, 8'h81);
    settle();
    chk(clock_output_enable, 20'h80281);
    @(posedge ref_clk) reset <= 1'b1;
    @(posedge ref_clk) reset <= 1'b0;
    rchk(8'h08, 8'h00);
    rchk(8'h07, 8'h08);
    results();
  end
endmodule : testbench
